// >>> verilog/rfwp_defs.svh
`ifndef RFWP_DEFS_SVH
`define RFWP_DEFS_SVH

`define RFWP_REG_WP_OVR      8'hC5
`define RFWP_REG_RING_FILT   8'hC6
`define RFWP_REG_WAKE_STAT   8'hD0
`define RFWP_REG_IRQ_STAT    8'hD1
`define RFWP_REG_IRQ_MASK    8'hD2

`define RFWP_WP_OVR_RESET    1'h0
`define RFWP_RING_FILT_RESET 3'h0
`define RFWP_IRQ_MASK_RESET  4'h0

`define RFWP_WP_OVR_BIT      0
`define RFWP_RING_FILT_W     3
`define RFWP_WAKE_RING_LSB   0
`define RFWP_WAKE_T2_BIT     3
`define RFWP_WAKE_T3_BIT     4
`define RFWP_IRQ_W           4
`define RFWP_IRQ_T3_BIT      3

`define RFWP_SYS_CLK_HZ      100000000
`define RFWP_RING_MIN_HZ     15
`define RFWP_RING_QUAL_MS    200
`define RFWP_RING_GAP_CYCLES  (`RFWP_SYS_CLK_HZ / `RFWP_RING_MIN_HZ)
`define RFWP_RING_QUAL_CYCLES (`RFWP_SYS_CLK_HZ / 1000 * `RFWP_RING_QUAL_MS)

`endif

// >>> verilog/rfwp_pkg.sv
package rfwp_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       wr;
        logic       rd;
    } rfwp_bus_req_t;

    typedef struct packed {
        logic wpInN;
        logic sel0N;
    } rfwp_wp_pins_t;

    typedef enum logic [1:0] {
        RF_IDLE   = 2'b00,
        RF_TRAIN  = 2'b01,
        RF_ACTIVE = 2'b10
    } rfwp_ring_state_t;

endpackage : rfwp_pkg

// >>> verilog/rfwp_sync.sv
`timescale 1ns/1ps
module rfwp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stage1_reg <= '1;
            syncOut    <= '1;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule : rfwp_sync

// >>> verilog/rfwp_ring_filter.sv
`timescale 1ns/1ps
module rfwp_ring_filter
    import rfwp_pkg::*;
#(
    parameter int GAP_CYCLES  = 6666666,
    parameter int QUAL_CYCLES = 20000000
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic ringS,
    input  wire logic filterEn,
    output logic      indN
);
    localparam int CW = $clog2(QUAL_CYCLES + GAP_CYCLES) + 1;

    rfwp_ring_state_t state_reg, state_next;
    logic [CW-1:0]    gapCnt_reg, gapCnt_next;
    logic [CW-1:0]    trainCnt_reg, trainCnt_next;
    logic             ringPrev_reg, ringPrev_next;
    logic             indN_next;
    logic             fall;
    logic             gapDone;

    assign fall    = ringPrev_reg & ~ringS;
    assign gapDone = !fall && (gapCnt_reg == CW'(GAP_CYCLES - 1));

    always_comb begin
        state_next    = state_reg;
        gapCnt_next   = fall ? '0 : gapCnt_reg + CW'(1);
        trainCnt_next = trainCnt_reg + CW'(1);
        ringPrev_next = ringS;
        indN_next     = 1'b1;
        if (!filterEn) begin
            state_next    = RF_IDLE;
            gapCnt_next   = '0;
            trainCnt_next = '0;
            indN_next     = ~fall;
        end else begin
            case (state_reg)
                RF_IDLE: begin
                    gapCnt_next   = '0;
                    trainCnt_next = '0;
                    if (fall) state_next = RF_TRAIN;
                end
                RF_TRAIN: begin
                    // Slower than the minimum rate breaks the train
                    if (gapDone) state_next = RF_IDLE;
                    else if (trainCnt_reg == CW'(QUAL_CYCLES - 1)) begin
                        state_next = RF_ACTIVE;
                        indN_next  = 1'b0;
                    end
                end
                RF_ACTIVE: begin
                    trainCnt_next = trainCnt_reg;
                    indN_next     = gapDone;
                    if (gapDone) state_next = RF_IDLE;
                end
                default: state_next = RF_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg    <= RF_IDLE;
            gapCnt_reg   <= '0;
            trainCnt_reg <= '0;
            ringPrev_reg <= 1'b1;
            indN         <= 1'b1;
        end else begin
            state_reg    <= state_next;
            gapCnt_reg   <= gapCnt_next;
            trainCnt_reg <= trainCnt_next;
            ringPrev_reg <= ringPrev_next;
            indN         <= indN_next;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_unfilt_edge: assert property (!filterEn && fall |=> !indN ##1 indN)
        else $error("unfiltered edge gave no one-cycle low pulse");
    a_train_qualify: assert property (filterEn && state_reg == RF_TRAIN && !gapDone
        && trainCnt_reg == CW'(QUAL_CYCLES - 1) && $stable(filterEn) |=> !indN)
        else $error("qualified pulse train did not pull indication low");
    a_train_release: assert property (filterEn && state_reg == RF_ACTIVE && gapDone |=> indN)
        else $error("indication stayed low after train stopped");
endmodule : rfwp_ring_filter

// >>> verilog/rfwp_top.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "rfwp_defs.svh"

// Behaviour
// - A set override bit makes the core see the drive write-protect as inactive while drive-select-0 (sel0N) is high.
// - Core write-protect high equals the pin high OR-ed with drive-select-0 AND the override bit.
// - The override acts equally on the drive connector path and the parallel-port drive path.
// - One override bit acts only while drive-select-0 (sel0N) is high, not for every attached drive.
// - Bits 7:1 of the override register always read zero.
// - Filter bit 0 qualifies a 15 Hz train lasting 200 ms on the main ring pin into a low level held until the train stops.
// - Filter bit 0 clear makes any falling edge of the main ring pin a ring indication.
// - Filter bit 1 applies the same train qualification to the first serial ring pin.
// - Filter bit 2 applies the same train qualification to the second serial ring pin.
// - Filter bit 1 clear makes any falling edge of the first serial ring pin an indication.
// - First-type wake events are edge latched until a status read and feed power-on.
// - Second-type wake events are passed as levels and clear only at their source.
// - Third-type wake events are edge latched until a status read but never feed power-on.
module rfwp_top
    import rfwp_pkg::*;
#(
    parameter int RING_GAP_CYCLES  = `RFWP_RING_GAP_CYCLES,
    parameter int RING_QUAL_CYCLES = `RFWP_RING_QUAL_CYCLES
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire rfwp_pkg::rfwp_bus_req_t busReq,
    output logic                  [7:0] regRdData,
    input  wire rfwp_pkg::rfwp_wp_pins_t fddWp,
    input  wire rfwp_pkg::rfwp_wp_pins_t ppWp,
    output logic                        fddWpCoreN,
    output logic                        ppWpCoreN,
    input  wire logic                   mainRingInN,
    input  wire logic                   serial1RingInN,
    input  wire logic                   serial2RingInN,
    output logic                  [2:0] ringIndN,
    input  wire logic                   wakeType2In,
    input  wire logic                   wakeType3In,
    output logic                        pwrOnReq,
    output logic                        irqOut
);
    import rfwp_pkg::*;

    localparam int RW = `RFWP_RING_FILT_W;
    localparam int IW = `RFWP_IRQ_W;

    // Pin synchronisers
    logic [8:0]          pinsS;
    rfwp_wp_pins_t       fddWpS;
    rfwp_wp_pins_t       ppWpS;
    logic [RW-1:0]       ringS;
    logic                wakeT2S;
    logic                wakeT3S;

    rfwp_sync #(
        .WIDTH (9)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        // Wake pins pass inverted so the all-ones reset reads as idle, no false edge
        .asyncIn ({fddWp, ppWp, serial2RingInN, serial1RingInN, mainRingInN,
                   ~wakeType2In, ~wakeType3In}),
        .syncOut (pinsS)
    );

    assign fddWpS  = pinsS[8:7];
    assign ppWpS   = pinsS[6:5];
    assign ringS   = pinsS[4:2];
    assign wakeT2S = ~pinsS[1];
    assign wakeT3S = ~pinsS[0];

    // Register decode
    logic wrWpOvr;
    logic wrRingFilt;
    logic wrIrqStat;
    logic wrIrqMask;
    logic rdWakeStat;

    assign wrWpOvr    = busReq.wr && busReq.addr == `RFWP_REG_WP_OVR;
    assign wrRingFilt = busReq.wr && busReq.addr == `RFWP_REG_RING_FILT;
    assign wrIrqStat  = busReq.wr && busReq.addr == `RFWP_REG_IRQ_STAT;
    assign wrIrqMask  = busReq.wr && busReq.addr == `RFWP_REG_IRQ_MASK;
    assign rdWakeStat = busReq.rd && busReq.addr == `RFWP_REG_WAKE_STAT;

    // Configuration registers
    logic          wpOvr_reg;
    logic          wpOvr_next;
    logic [RW-1:0] ringFilt_reg;
    logic [RW-1:0] ringFilt_next;
    logic [IW-1:0] irqMask_reg;
    logic [IW-1:0] irqMask_next;

    always_comb begin
        wpOvr_next    = wpOvr_reg;
        ringFilt_next = ringFilt_reg;
        irqMask_next  = irqMask_reg;
        if (wrWpOvr) begin
            wpOvr_next = busReq.wrData[`RFWP_WP_OVR_BIT];
        end
        if (wrRingFilt) begin
            ringFilt_next = busReq.wrData[RW-1:0];
        end
        if (wrIrqMask) begin
            irqMask_next = busReq.wrData[IW-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wpOvr_reg    <= `RFWP_WP_OVR_RESET;
            ringFilt_reg <= `RFWP_RING_FILT_RESET;
            irqMask_reg  <= `RFWP_IRQ_MASK_RESET;
        end else begin
            wpOvr_reg    <= wpOvr_next;
            ringFilt_reg <= ringFilt_next;
            irqMask_reg  <= irqMask_next;
        end
    end

    // Write-protect paths
    logic fddWpCoreN_next;
    logic ppWpCoreN_next;

    always_comb begin
        // Same bit on both paths, gated by drive-select-0 (sel0N)
        fddWpCoreN_next = fddWpS.wpInN | (fddWpS.sel0N & wpOvr_reg);
        ppWpCoreN_next  = ppWpS.wpInN | (ppWpS.sel0N & wpOvr_reg);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fddWpCoreN <= 1'b1;
            ppWpCoreN  <= 1'b1;
        end else begin
            fddWpCoreN <= fddWpCoreN_next;
            ppWpCoreN  <= ppWpCoreN_next;
        end
    end

    // Ring filters, one per ring pin
    genvar gi;
    generate
        for (gi = 0; gi < RW; gi++) begin : g_ring
            rfwp_ring_filter #(
                .GAP_CYCLES  (RING_GAP_CYCLES),
                .QUAL_CYCLES (RING_QUAL_CYCLES)
            ) u_filt (
                .sys_clk  (sys_clk),
                .rst      (rst),
                .ringS    (ringS[gi]),
                .filterEn (ringFilt_reg[gi]),
                .indN     (ringIndN[gi])
            );
        end
    endgenerate

    // Wake latches and interrupt status
    logic [RW-1:0] ringIndPrev_reg;
    logic [RW-1:0] ringIndPrev_next;
    logic [RW-1:0] ringEvt;
    logic          wakeT3Prev_reg;
    logic          wakeT3Prev_next;
    logic          wakeT3Evt;
    logic [RW-1:0] wakeT1_reg;
    logic [RW-1:0] wakeT1_next;
    logic          wakeT3_reg;
    logic          wakeT3_next;
    logic [IW-1:0] irqStat_reg;
    logic [IW-1:0] irqStat_next;
    logic [IW-1:0] irqClr;
    logic          pwrOnReq_next;
    logic          irqOut_next;

    assign ringEvt   = ringIndPrev_reg & ~ringIndN;
    assign wakeT3Evt = wakeT3S & ~wakeT3Prev_reg;
    assign irqClr    = wrIrqStat ? busReq.wrData[IW-1:0] : '0;

    always_comb begin
        ringIndPrev_next = ringIndN;
        wakeT3Prev_next  = wakeT3S;
        // A new edge beats the clearing read
        wakeT1_next  = ringEvt | (wakeT1_reg & {RW{~rdWakeStat}});
        wakeT3_next  = wakeT3Evt | (wakeT3_reg & ~rdWakeStat);
        irqStat_next = {wakeT3Evt, ringEvt} | (irqStat_reg & ~irqClr);
        // Type 3 stays out of the supply turn-on term
        pwrOnReq_next = (|wakeT1_next) | wakeT2S;
        irqOut_next   = |(irqStat_next & irqMask_next);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ringIndPrev_reg <= '1;
            wakeT3Prev_reg  <= 1'b0;
            wakeT1_reg      <= '0;
            wakeT3_reg      <= 1'b0;
            irqStat_reg     <= '0;
            pwrOnReq        <= 1'b0;
            irqOut          <= 1'b0;
        end else begin
            ringIndPrev_reg <= ringIndPrev_next;
            wakeT3Prev_reg  <= wakeT3Prev_next;
            wakeT1_reg      <= wakeT1_next;
            wakeT3_reg      <= wakeT3_next;
            irqStat_reg     <= irqStat_next;
            pwrOnReq        <= pwrOnReq_next;
            irqOut          <= irqOut_next;
        end
    end

    // Read port, data valid only in the cycle after the strobe
    logic [7:0] regRdData_next;

    always_comb begin
        regRdData_next = 8'h00;
        if (busReq.rd) begin
            case (busReq.addr)
                `RFWP_REG_WP_OVR: begin
                    regRdData_next = {7'h00, wpOvr_reg};
                end
                `RFWP_REG_RING_FILT: begin
                    regRdData_next = {5'h00, ringFilt_reg};
                end
                `RFWP_REG_WAKE_STAT: begin
                    // Type 2 shows the live level, never held
                    regRdData_next = {3'h0, wakeT3_reg, wakeT2S, wakeT1_reg};
                end
                `RFWP_REG_IRQ_STAT: begin
                    regRdData_next = {4'h0, irqStat_reg};
                end
                `RFWP_REG_IRQ_MASK: begin
                    regRdData_next = {4'h0, irqMask_reg};
                end
                default: begin
                    regRdData_next = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= regRdData_next;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_wake_read;
        busReq.rd && busReq.addr == `RFWP_REG_WAKE_STAT;
    endsequence

    sequence s_ovr_read;
        busReq.rd && busReq.addr == `RFWP_REG_WP_OVR;
    endsequence

    sequence s_irq_clear;
        wrIrqStat;
    endsequence

    sequence s_type3_edge;
        wakeT3Evt;
    endsequence

    sequence s_filt_read;
        busReq.rd && busReq.addr == `RFWP_REG_RING_FILT;
    endsequence

    sequence s_ovr_write;
        wrWpOvr;
    endsequence

    a_fdd_wp_path: assert property ($past(rst, 3) == 1'b0 |->
        fddWpCoreN == ($past(fddWp.wpInN, 3) | ($past(fddWp.sel0N, 3) & $past(wpOvr_reg))))
        else $error("drive write-protect to core wrong");

    a_pp_wp_path: assert property ($past(rst, 3) == 1'b0 |->
        ppWpCoreN == ($past(ppWp.wpInN, 3) | ($past(ppWp.sel0N, 3) & $past(wpOvr_reg))))
        else $error("parallel-port write-protect to core wrong");

    a_ovr_both_paths: assert property (wpOvr_reg && fddWpS.sel0N && ppWpS.sel0N
        |=> fddWpCoreN && ppWpCoreN)
        else $error("override bit did not act on both paths alike");

    a_ovr_reserved: assert property (s_ovr_read |=> regRdData[7:1] == 7'h00
        && regRdData[0] == $past(wpOvr_reg))
        else $error("override reserved bits not zero");

    a_type1_hold: assert property (ringEvt[0] |=> wakeT1_reg[0] && pwrOnReq)
        else $error("ring wake edge not latched to power-on");

    a_type1_clear: assert property (s_wake_read ##0 !ringEvt[0] && wakeT1_reg[0]
        |=> !wakeT1_reg[0] ##0 regRdData[0])
        else $error("wake status read did not clear latch");

    a_type2_level: assert property (busReq.rd && busReq.addr == `RFWP_REG_WAKE_STAT
        |=> regRdData[`RFWP_WAKE_T2_BIT] == $past(wakeT2S))
        else $error("type 2 wake bit not live level");

    a_type3_no_pwr: assert property (wakeT3_reg && wakeT1_reg == '0 && !wakeT2S
        && !(|ringEvt) |=> !pwrOnReq)
        else $error("type 3 wake drove power-on");

    a_irq_level: assert property (irqOut == |(irqStat_reg & irqMask_reg))
        else $error("interrupt output out of step with status");

    a_wp_ovr_write: assert property (s_ovr_write |=> wpOvr_reg == $past(busReq.wrData[`RFWP_WP_OVR_BIT]))
        else $error("override bit write not taken");

    a_ring_filt_write: assert property (wrRingFilt |=> ringFilt_reg == $past(busReq.wrData[RW-1:0]))
        else $error("ring filter select write not taken");

    a_filt_readback: assert property (s_filt_read |=> regRdData == {5'h00, $past(ringFilt_reg)})
        else $error("ring filter select read back wrong");

    a_type1_serial: assert property (ringEvt[1] |=> wakeT1_reg[1] && pwrOnReq)
        else $error("first serial ring wake edge not latched");

    a_type1_serial_two: assert property (ringEvt[2] |=> wakeT1_reg[2] && pwrOnReq)
        else $error("second serial ring wake edge not latched");

    a_type2_pwr: assert property (wakeT2S |=> pwrOnReq)
        else $error("type 2 wake level did not request power-on");

    a_type3_latch: assert property (s_type3_edge |=> wakeT3_reg && irqStat_reg[3])
        else $error("type 3 wake edge not latched");

    a_type3_clear: assert property (s_wake_read ##0 !wakeT3Evt |=> !wakeT3_reg)
        else $error("wake status read did not clear type 3 latch");

    a_irq_set_wins: assert property (s_irq_clear ##0 ringEvt[0] |=> irqStat_reg[0])
        else $error("clear beat a new interrupt event");

    a_irq_clear: assert property (s_irq_clear ##0 busReq.wrData[3] && !wakeT3Evt |=> !irqStat_reg[3])
        else $error("interrupt status bit not cleared by write of one");

    a_rd_idle_zero: assert property (!busReq.rd |=> regRdData == 8'h00)
        else $error("read data not zero outside read cycle");
endmodule : rfwp_top

// >>> bench/rfwp_far_side.sv
`timescale 1ns/1ps
module rfwp_far_side (
    input  wire logic       sys_clk,
    input  wire logic [2:0] trSel,
    input  wire logic [7:0] trHalf,
    input  wire logic [7:0] trEdges,
    input  wire logic       trGo,
    output logic            mainRingInN,
    output logic            serial1RingInN,
    output logic            serial2RingInN
);
    logic [7:0] cnt = 8'h00;
    logic [7:0] left = 8'h00;
    logic       lvl = 1'b1;
    logic       busy = 1'b0;

    // Modem toggles its ring line, then releases it to the pull-up level
    always @(posedge sys_clk) begin
        if (trGo) begin
            left <= trEdges;
            cnt <= 8'h00;
            lvl <= 1'b0;
            busy <= 1'b1;
        end else if (busy) begin
            if (cnt == trHalf - 8'h01) begin
                cnt <= 8'h00;
                lvl <= ~lvl;
                if (lvl == 1'b0) begin
                    left <= left - 8'h01;
                    busy <= (left != 8'h01);
                end
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
    assign mainRingInN    = trSel[0] ? lvl : 1'b1;
    assign serial1RingInN = trSel[1] ? lvl : 1'b1;
    assign serial2RingInN = trSel[2] ? lvl : 1'b1;
endmodule : rfwp_far_side

// >>> bench/rfwp_top_tb.sv
`timescale 1ns/1ps
`include "rfwp_defs.svh"
module rfwp_top_tb;
    import rfwp_pkg::*;
    localparam int GAP  = 8;
    localparam int QUAL = 20;
    logic          sys_clk = 1'b0;
    logic          rst = 1'b1;
    rfwp_bus_req_t busReq = '0;
    rfwp_wp_pins_t fddWp = 2'b11;
    rfwp_wp_pins_t ppWp = 2'b11;
    logic          wakeType2In = 1'b0;
    logic          wakeType3In = 1'b0;
    logic [7:0]    regRdData;
    logic          fddWpCoreN;
    logic          ppWpCoreN;
    logic          pwrOnReq;
    logic          irqOut;
    logic [2:0]    ringIndN;
    logic          mainRingInN;
    logic          serial1RingInN;
    logic          serial2RingInN;
    logic [2:0]    trSel = 3'h0;
    logic [7:0]    trHalf = 8'h04;
    logic [7:0]    trEdges = 8'h01;
    logic          trGo = 1'b0;
    int            n_mismatch = 0;
    int            n_tests = 0;
    logic [31:0]   seed = 32'hF3EA972A;
    logic [7:0]    mOvr = 8'h00;
    logic [7:0]    mIrq = 8'h00;
    logic [7:0]    mWake = 8'h00;

    always #5 sys_clk = ~sys_clk;

    rfwp_top #(.RING_GAP_CYCLES(GAP), .RING_QUAL_CYCLES(QUAL)) DUT (
        .sys_clk(sys_clk), .rst(rst), .busReq(busReq), .regRdData(regRdData),
        .fddWp(fddWp), .ppWp(ppWp), .fddWpCoreN(fddWpCoreN), .ppWpCoreN(ppWpCoreN),
        .mainRingInN(mainRingInN), .serial1RingInN(serial1RingInN),
        .serial2RingInN(serial2RingInN), .ringIndN(ringIndN), .wakeType2In(wakeType2In),
        .wakeType3In(wakeType3In), .pwrOnReq(pwrOnReq), .irqOut(irqOut));

    rfwp_far_side modem (
        .sys_clk(sys_clk), .trSel(trSel), .trHalf(trHalf), .trEdges(trEdges), .trGo(trGo),
        .mainRingInN(mainRingInN), .serial1RingInN(serial1RingInN),
        .serial2RingInN(serial2RingInN));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_reg

    task automatic chk_pin(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_pin

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        busReq.addr <= a;
        busReq.wrData <= d;
        busReq.wr <= 1'b1;
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
    endtask : reg_wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        busReq.addr <= a;
        busReq.rd <= 1'b1;
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
        #1;
        chk_reg("regRdData", exp, regRdData);
    endtask : rd_chk

    // Run a ring pattern and count the cycles the indication sits low
    task automatic ring_run(input int i, input int half, input int edges, output int low);
        @(posedge sys_clk);
        trSel <= 3'h1 << i;
        trHalf <= half[7:0];
        trEdges <= edges[7:0];
        trGo <= 1'b1;
        @(posedge sys_clk);
        trGo <= 1'b0;
        low = 0;
        repeat (2 * half * edges + GAP + QUAL + 10) begin
            @(posedge sys_clk);
            #1;
            if (ringIndN[i] === 1'b0) low++;
        end
    endtask : ring_run

    initial begin
        int low;
        int exp;
        tick(20);
        rst <= 1'b0;
        tick(2);
        // No wake edge may be latched out of reset
        rd_chk(`RFWP_REG_WAKE_STAT, 8'h00);
        rd_chk(`RFWP_REG_IRQ_STAT, 8'h00);
        reg_wr(`RFWP_REG_IRQ_STAT, 8'hFF);
        rd_chk(`RFWP_REG_WP_OVR, 8'h00);
        rd_chk(`RFWP_REG_RING_FILT, 8'h00);
        rd_chk(`RFWP_REG_IRQ_MASK, 8'h00);
        rd_chk(`RFWP_REG_IRQ_STAT, 8'h00);
        seed = lfsr_next(seed);
        rd_chk({4'hA, seed[3:0]}, 8'h00);
        reg_wr(`RFWP_REG_WP_OVR, 8'hFF);
        rd_chk(`RFWP_REG_WP_OVR, 8'h01);
        reg_wr(`RFWP_REG_RING_FILT, 8'hF8);
        rd_chk(`RFWP_REG_RING_FILT, 8'h00);
        $display("test registers done");
        for (int k = 0; k < 8; k++) begin
            mOvr = {7'h00, k[2]};
            reg_wr(`RFWP_REG_WP_OVR, mOvr | 8'hFE);
            seed = lfsr_next(seed);
            @(posedge sys_clk);
            fddWp <= rfwp_wp_pins_t'(k[1:0]);
            ppWp <= rfwp_wp_pins_t'(seed[1:0]);
            tick(5);
            chk_pin("fddWpCoreN", fddWp.wpInN | (fddWp.sel0N & mOvr[0]), fddWpCoreN);
            chk_pin("ppWpCoreN", ppWp.wpInN | (ppWp.sel0N & mOvr[0]), ppWpCoreN);
        end
        $display("test write protect done");
        reg_wr(`RFWP_REG_RING_FILT, 8'h00);
        for (int i = 0; i < 3; i++) begin
            ring_run(i, 4, 1, low);
            chk_reg("unfilteredLow", 8'h01, low[7:0]);
            mWake[i] = 1'b1;
            mIrq[i] = 1'b1;
        end
        chk_pin("pwrOnReq", 1'b1, pwrOnReq);
        chk_pin("irqOutMasked", 1'b0, irqOut);
        rd_chk(`RFWP_REG_IRQ_STAT, mIrq);
        reg_wr(`RFWP_REG_IRQ_MASK, 8'h0F);
        tick(2);
        chk_pin("irqOutOn", 1'b1, irqOut);
        reg_wr(`RFWP_REG_IRQ_STAT, mIrq);
        mIrq = 8'h00;
        tick(2);
        chk_pin("irqOutOff", 1'b0, irqOut);
        rd_chk(`RFWP_REG_WAKE_STAT, mWake);
        mWake = 8'h00;
        rd_chk(`RFWP_REG_WAKE_STAT, mWake);
        tick(1);
        chk_pin("pwrOnReqClr", 1'b0, pwrOnReq);
        $display("test unfiltered ring done");
        reg_wr(`RFWP_REG_RING_FILT, 8'h07);
        for (int i = 0; i < 3; i++) begin
            // Too slow a train never qualifies
            ring_run(i, 5, 6, low);
            chk_reg("slowTrainLow", 8'h00, low[7:0]);
            ring_run(i, 3, 12, low);
            exp = 11 * 6 + GAP - QUAL;
            chk_reg("trainLen", exp[7:0], low[7:0]);
            mWake[i] = 1'b1;
            mIrq[i] = 1'b1;
        end
        rd_chk(`RFWP_REG_IRQ_STAT, mIrq);
        reg_wr(`RFWP_REG_IRQ_STAT, mIrq);
        mIrq = 8'h00;
        rd_chk(`RFWP_REG_WAKE_STAT, mWake);
        mWake = 8'h00;
        $display("test filtered ring done");
        @(posedge sys_clk);
        wakeType2In <= 1'b1;
        tick(5);
        chk_pin("pwrOnType2", 1'b1, pwrOnReq);
        rd_chk(`RFWP_REG_WAKE_STAT, 8'h08);
        rd_chk(`RFWP_REG_WAKE_STAT, 8'h08);
        @(posedge sys_clk);
        wakeType2In <= 1'b0;
        tick(5);
        chk_pin("pwrOffType2", 1'b0, pwrOnReq);
        rd_chk(`RFWP_REG_WAKE_STAT, 8'h00);
        @(posedge sys_clk);
        wakeType3In <= 1'b1;
        tick(5);
        chk_pin("pwrType3", 1'b0, pwrOnReq);
        chk_pin("irqType3", 1'b1, irqOut);
        rd_chk(`RFWP_REG_IRQ_STAT, 8'h08);
        rd_chk(`RFWP_REG_WAKE_STAT, 8'h10);
        rd_chk(`RFWP_REG_WAKE_STAT, 8'h00);
        reg_wr(`RFWP_REG_IRQ_STAT, 8'h08);
        tick(2);
        chk_pin("irqType3Clr", 1'b0, irqOut);
        $display("test wake types done");
        tally_and_finish();
    end

    // Whole sequence needs about a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : rfwp_top_tb
